//--- hotplug_timer_cfg_regs_consts.svh
// Constants for the hot-plug timer configuration function
`ifndef HOTPLUG_TIMER_CFG_REGS_CONSTS_SVH
`define HOTPLUG_TIMER_CFG_REGS_CONSTS_SVH

// Configuration byte offsets
`define HPT_OFS_HEADER        8'h0e
`define HPT_OFS_SUBSYS        8'h2c
`define HPT_OFS_SUBSYS_ID     8'h2e
`define HPT_OFS_TIMER         8'hb0

// Header type fields
`define HPT_HDR_MULTI_BIT     7
`define HPT_HDR_MULTI_VAL     1'b1
`define HPT_HDR_FORMAT_VAL    7'h00

// Timer register field positions
`define HPT_PRESCALE_LSB      0
`define HPT_COUNT_LSB         5
`define HPT_ENABLE_BIT        15
`define HPT_STATUS_BIT        16

// Timer reset values and recommended prescale
`define HPT_PRESCALE_RST      5'h00
`define HPT_COUNT_RST         10'h000
`define HPT_PRESCALE_RECOMMENDED 5'h15

`endif

//--- hotplug_timer_cfg_regs_pkg.sv
// Types shared by the hot-plug timer configuration function
package hotplug_timer_cfg_regs_pkg;

  // One-hot timer states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_RUN     = 3'b010,
    ST_EXPIRED = 3'b100
  } timer_state_t;

endpackage : hotplug_timer_cfg_regs_pkg

//--- hotplug_prescaler.sv
// Free-running power-of-two prescaler producing decrement ticks
`timescale 1ns/1ps
`default_nettype none
module hotplug_prescaler
  import hotplug_timer_cfg_regs_pkg::*;
#(
  parameter int PRESCALE_WIDTH = 5
) (
  input  wire logic                      i_clock,
  input  wire logic                      i_rstn,
  input  wire logic [PRESCALE_WIDTH-1:0] i_prescale,
  output logic                           o_tick
);

  localparam int CW = 2 ** PRESCALE_WIDTH;

  // Counter must stay a sane width; refused at elaboration
  if (PRESCALE_WIDTH < 1 || PRESCALE_WIDTH > 5) begin : g_bad_width
    $error("PRESCALE_WIDTH out of range");
  end

  // All state of the prescaler
  typedef struct packed {
    logic [CW-1:0] cnt;   // Free-running bus clock count
    logic          tick;  // Registered tick
  } pre_state_t;

  pre_state_t st;       // Current state
  pre_state_t next_st;  // Next state
  logic [CW-1:0] mask;  // Low bits that must all be ones

  // Tick once the low prescale bits wrap; free running, so the first
  // interval after enabling is partial, which gives the lower bound
  always_comb begin
    next_st     = st;
    mask        = (CW'(1) << i_prescale) - CW'(1);
    next_st.cnt = st.cnt + CW'(1);
    next_st.tick = ((st.cnt & mask) == mask);
  end

  // State register
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_tick = st.tick;

endmodule : hotplug_prescaler
`default_nettype wire

//--- hotplug_timer_cfg_regs.sv
// Configuration function with header, subsystem identity and hot-plug timer
`timescale 1ns/1ps
`default_nettype none
`include "hotplug_timer_cfg_regs_consts.svh"
module hotplug_timer_cfg_regs
  import hotplug_timer_cfg_regs_pkg::*;
#(
  parameter int          PRESCALE_WIDTH = 5,
  parameter int          COUNT_WIDTH    = 10,
  parameter logic [15:0] SUBSYS_VENDOR_RST = 16'h1a2b, // Arbitrary value
  parameter logic [15:0] SUBSYS_ID_RST     = 16'h3c4d  // Arbitrary value
) (
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  output logic [31:0]      o_cfg_rdata,
  output logic             o_cfg_rvalid,
  output logic             o_hotplug_irq_out
);

  // Fields must fit the fixed register layout; refused at elaboration
  if (PRESCALE_WIDTH != 5 || COUNT_WIDTH != 10) begin : g_bad_layout
    $error("Timer field widths must match register layout");
  end

  // All state of the function
  typedef struct packed {
    logic [15:0]            subsystem_vendor_ident;      // Subsystem vendor identity
    logic [15:0]            subsystem_ident;       // Subsystem identity
    logic [3:0]             written;   // Per-byte write-once flags
    logic                   status;    // Timer expiry status
    logic                   enable;    // Interrupt enable
    logic [COUNT_WIDTH-1:0] count;     // Programmed interval count
    logic [PRESCALE_WIDTH-1:0] prescale; // Programmed prescale
    logic [COUNT_WIDTH-1:0] remaining; // Intervals left
    timer_state_t           tstate;    // Timer state
    logic [31:0]            rdata;     // Read data
    logic                   rvalid;    // Read answer strobe
  } regs_t;

  regs_t st;        // Current state
  regs_t next_st;   // Next state
  logic  tick;      // Prescaler tick
  logic [31:0] wmask;     // Byte-enable mask
  logic [31:0] tword;     // Timer word as stored
  logic [31:0] tnew;      // Timer word after write merge
  logic [31:0] idnew;     // Identity word after write merge
  logic        hit_hdr;   // Header dword decode
  logic        hit_id;    // Identity dword decode
  logic        hit_tim;   // Timer dword decode

  // Expand byte enables into a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  // Merge write data under a mask
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction : merge

  // Single prescaler: the function has one timer only
  // one timer instance
  hotplug_prescaler #(
    .PRESCALE_WIDTH (PRESCALE_WIDTH)
  ) u_prescaler (
    .i_clock    (i_clock),
    .i_rstn     (i_rstn),
    .i_prescale (st.prescale),
    .o_tick     (tick)
  );

  // Dword decode; header sits in byte lane 2 of dword 0x0c
  assign hit_hdr = (i_cfg_addr[7:2] == 6'(`HPT_OFS_HEADER >> 2));
  assign hit_id  = (i_cfg_addr[7:2] == 6'(`HPT_OFS_SUBSYS >> 2));
  assign hit_tim = (i_cfg_addr[7:2] == 6'(`HPT_OFS_TIMER >> 2));
  assign wmask   = be_mask(i_cfg_be);
  assign tword   = {15'h0000, st.status, st.enable, st.count, st.prescale};

  // Register writes, timer sequencing and read answer
  always_comb begin
    next_st = st;
    // Identity bytes only take lanes not yet written
    // first write per byte
    idnew = merge({st.subsystem_ident, st.subsystem_vendor_ident}, i_cfg_wdata,
                  wmask & ~be_mask(st.written));
    tnew  = merge(tword, i_cfg_wdata, wmask);
    next_st.rvalid = i_cfg_rd;
    next_st.rdata  = 32'h0000_0000;

    // Read mux; unmapped dwords read zero
    if (i_cfg_rd) begin
      if (hit_hdr) begin
        next_st.rdata[23:16] = {`HPT_HDR_MULTI_VAL, `HPT_HDR_FORMAT_VAL};
      end else if (hit_id) begin
        next_st.rdata = {st.subsystem_ident, st.subsystem_vendor_ident};
      end else if (hit_tim) begin
        next_st.rdata = tword;
      end
    end

    // Configuration writes
    if (i_cfg_wr && hit_id) begin
      next_st.subsystem_vendor_ident    = idnew[15:0];
      next_st.subsystem_ident     = idnew[31:16];
      next_st.written = st.written | i_cfg_be;
    end
    if (i_cfg_wr && hit_tim) begin
      next_st.prescale = tnew[`HPT_PRESCALE_LSB +: PRESCALE_WIDTH];
      next_st.count    = tnew[`HPT_COUNT_LSB +: COUNT_WIDTH];
      next_st.enable   = tnew[`HPT_ENABLE_BIT];
      if (i_cfg_be[2] && i_cfg_wdata[`HPT_STATUS_BIT]) begin
        next_st.status = 1'b0;
      end
    end

    // Timer sequencer
    case (st.tstate)
      ST_IDLE: begin
        if (st.enable) begin
          next_st.remaining = st.count;
          next_st.tstate    = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!st.enable) begin
          next_st.tstate = ST_IDLE;
        end else if (tick) begin
          if (st.remaining <= COUNT_WIDTH'(1)) begin
            next_st.remaining = '0;
            next_st.tstate    = ST_EXPIRED;
            // expiry sets status, wins over clear
            next_st.status    = 1'b1;
          end else begin
            next_st.remaining = st.remaining - COUNT_WIDTH'(1);
          end
        end
      end
      ST_EXPIRED: begin
        // Hold until software drops enable to re-arm
        if (!st.enable) begin
          next_st.tstate = ST_IDLE;
        end
      end
      default: begin
        next_st.tstate = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      st           <= '0;
      st.subsystem_vendor_ident      <= SUBSYS_VENDOR_RST;
      st.subsystem_ident       <= SUBSYS_ID_RST;
      st.count     <= `HPT_COUNT_RST;
      st.prescale  <= `HPT_PRESCALE_RST;
      st.tstate    <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Interrupt level while status stands and enable is set
  // enabled expiry raises interrupt
  assign o_hotplug_irq_out = st.status & st.enable;
  assign o_cfg_rdata       = st.rdata;
  assign o_cfg_rvalid      = st.rvalid;

  // Assertions share the bus clock and the synchronous reset
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  chk_tick_decrements: assert property (
    st.tstate == ST_RUN && st.enable && tick && st.remaining > 10'd1
    |=> st.remaining == $past(st.remaining) - 10'd1)
    else $error("Remaining count did not decrement on tick");
  chk_load_on_enable: assert property (
    st.tstate == ST_IDLE && st.enable |=> st.tstate == ST_RUN &&
    st.remaining == $past(st.count))
    else $error("Count not loaded on enable");
  chk_no_tick_hold: assert property (
    st.tstate == ST_RUN && st.enable && !tick |=> st.remaining == $past(st.remaining))
    else $error("Remaining changed without a tick");
  chk_expiry_status: assert property (
    st.tstate == ST_RUN && st.enable && tick && st.remaining <= 10'd1
    |=> st.status && st.tstate == ST_EXPIRED)
    else $error("Expiry did not set status");
  chk_irq_level: assert property (
    st.tstate == ST_RUN && st.enable && tick && st.remaining == 10'd1 &&
    !(i_cfg_wr && hit_tim) |=> o_hotplug_irq_out)
    else $error("Interrupt not raised on expiry");
  chk_status_sticky: assert property (
    $fell(st.status) |-> $past(i_cfg_wr) && $past(hit_tim) && $past(i_cfg_be[2]) &&
    $past(i_cfg_wdata[`HPT_STATUS_BIT]))
    else $error("Status cleared without write one");
  // Status may rise only from a timer expiry
  chk_status_from_expiry: assert property (
    $rose(st.status) |-> $past(st.tstate) == ST_RUN && $past(tick))
    else $error("Status set without timer expiry");
  chk_write_once: assert property (
    st.written[0] |=> st.subsystem_vendor_ident[7:0] == $past(st.subsystem_vendor_ident[7:0]))
    else $error("Written identity byte changed");
  chk_header_value: assert property (
    i_cfg_rd && hit_hdr |=> o_cfg_rvalid && o_cfg_rdata[23:16] == 8'h80)
    else $error("Header type read wrong");
  chk_stop_disabled: assert property (
    !st.enable |=> st.tstate != ST_EXPIRED || $past(st.tstate) == ST_EXPIRED)
    else $error("Timer advanced while disabled");

  // Main scenarios worth seeing in coverage
  cov_expiry: cover property (st.tstate == ST_RUN ##1 st.tstate == ST_EXPIRED);
  cov_stop: cover property (st.tstate == ST_RUN ##1 st.tstate == ST_IDLE);
  cov_clear: cover property (st.status ##1 !st.status);
  cov_rearm: cover property (st.tstate == ST_EXPIRED ##[1:20] st.tstate == ST_RUN);

endmodule : hotplug_timer_cfg_regs
`default_nettype wire

//--- test_hotplug_timer_cfg_regs.sv
// Self-checking bench for the hot-plug timer configuration function
`timescale 1ns/1ps
`default_nettype none
`include "hotplug_timer_cfg_regs_consts.svh"
module test_hotplug_timer_cfg_regs
  import hotplug_timer_cfg_regs_pkg::*;
;
  localparam logic [15:0] SV_RST = 16'h5a01; // Arbitrary value
  localparam logic [15:0] SI_RST = 16'h6b02; // Arbitrary value
  logic        i_clock = 1'b0;  // Bus clock
  logic        i_rstn  = 1'b0;  // Sync reset, active low
  logic        i_cfg_wr = 1'b0; // Write strobe
  logic        i_cfg_rd = 1'b0; // Read strobe
  logic [7:0]  i_cfg_addr = 8'h00;
  logic [3:0]  i_cfg_be = 4'h0;
  logic [31:0] i_cfg_wdata = 32'h0;
  logic [31:0] o_cfg_rdata;
  logic        o_cfg_rvalid;
  logic        o_hotplug_irq_out;
  int          error_cnt = 0;
  int          n_compared = 0;

  hotplug_timer_cfg_regs #(
    .SUBSYS_VENDOR_RST(SV_RST),
    .SUBSYS_ID_RST    (SI_RST)
  ) DUT (
    .i_clock          (i_clock),
    .i_rstn           (i_rstn),
    .i_cfg_wr         (i_cfg_wr),
    .i_cfg_rd         (i_cfg_rd),
    .i_cfg_addr       (i_cfg_addr),
    .i_cfg_be         (i_cfg_be),
    .i_cfg_wdata      (i_cfg_wdata),
    .o_cfg_rdata      (o_cfg_rdata),
    .o_cfg_rvalid     (o_cfg_rvalid),
    .o_hotplug_irq_out(o_hotplug_irq_out)
  );

  // 100 MHz clock
  always #5 i_clock = ~i_clock;

  // Compare one value, count it
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Verdict and end of run
  task automatic summarize();
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // One-cycle write pulse
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge i_clock);
    i_cfg_wr    <= 1'b1;
    i_cfg_addr  <= a;
    i_cfg_be    <= b;
    i_cfg_wdata <= d;
    @(posedge i_clock);
    i_cfg_wr <= 1'b0;
  endtask : wr

  // Read; answer is registered at the taking edge and checked 1 ns after it
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clock);
    i_cfg_rd   <= 1'b1;
    i_cfg_addr <= a;
    @(posedge i_clock);
    i_cfg_rd <= 1'b0;
    // Answer registered at that taking edge; look while it stands
    #1;
    chk({31'h0, o_cfg_rvalid}, 32'h1);
    chk(o_cfg_rdata, exp);
  endtask : rd_chk

  // Timer word from its fields
  function automatic logic [31:0] tw(logic st, logic en, logic [9:0] c, logic [4:0] p);
    return {15'h0, st, en, c, p};
  endfunction : tw

  // Watchdog, far beyond the expected run
  initial begin
    #400000;
    error_cnt++;
    summarize();
  end

  // Main sequence
  initial begin
    logic [31:0] d1;
    logic [31:0] d2;
    logic [31:0] ex;
    logic [9:0]  c;
    logic [4:0]  p;
    int          k;
    int          lo;
    int          hi;
    void'($urandom(66));
    repeat (16) @(posedge i_clock);
    i_rstn <= 1'b1;
    // Reset values, header fixed, unmapped dword
    rd_chk(8'h0c, 32'h0080_0000);
    rd_chk(8'h2c, {SI_RST, SV_RST});
    rd_chk(8'hb0, 32'h0);
    wr(8'h0c, 4'hf, 32'hffff_ffff);
    wr(8'h40, 4'hf, 32'hffff_ffff);
    rd_chk(8'h0c, 32'h0080_0000);
    rd_chk(8'h40, 32'h0);
    // Identity bytes take only their first write
    d1 = $urandom();
    d2 = $urandom();
    wr(8'h2c, 4'b0101, d1);
    rd_chk(8'h2c, {SI_RST[15:8], d1[23:16], SV_RST[15:8], d1[7:0]});
    wr(8'h2c, 4'hf, d2);
    ex = {d2[31:24], d1[23:16], d2[15:8], d1[7:0]};
    rd_chk(8'h2c, ex);
    wr(8'h2f, 4'hf, ~d2);
    rd_chk(8'h2c, ex);
    // Timer runs: count 0 corner, then random counts
    for (int i = 0; i < 6; i++) begin
      p = 5'(i % 4);
      c = (i == 0) ? 10'h0 : 10'($urandom_range(1, 4));
      lo = (c > 0) ? ((int'(c) - 1) << p) : 0;
      hi = ((c > 0) ? (int'(c) << p) : (1 << p)) + 6;
      wr(8'hb0, 4'hf, tw(1'b0, 1'b1, c, p));
      k = 0;
      while (o_hotplug_irq_out !== 1'b1 && k < 200) begin
        @(posedge i_clock);
        #1;
        k++;
      end
      chk({31'h0, k >= lo && k <= hi}, 32'h1);
      rd_chk(8'hb0, tw(1'b1, 1'b1, c, p));
      // Writing zero to status and ones to reserved bits changes nothing
      wr(8'hb0, 4'hf, 32'hfffe_0000 | tw(1'b0, 1'b1, c, p));
      rd_chk(8'hb0, tw(1'b1, 1'b1, c, p));
      chk({31'h0, o_hotplug_irq_out}, 32'h1);
      wr(8'hb0, 4'hf, tw(1'b1, 1'b0, c, p));
      rd_chk(8'hb0, tw(1'b0, 1'b0, c, p));
      chk({31'h0, o_hotplug_irq_out}, 32'h0);
    end
    // Count loaded but enable clear: no expiry
    wr(8'hb0, 4'hf, tw(1'b0, 1'b0, 10'h1, 5'h0));
    repeat (30) @(posedge i_clock);
    #1;
    chk({31'h0, o_hotplug_irq_out}, 32'h0);
    rd_chk(8'hb0, tw(1'b0, 1'b0, 10'h1, 5'h0));
    wr(8'hb0, 4'hf, tw(1'b0, 1'b1, 10'h4, 5'h3));
    repeat (5) @(posedge i_clock);
    wr(8'hb0, 4'hf, tw(1'b0, 1'b0, 10'h4, 5'h3));
    repeat (60) @(posedge i_clock);
    #1;
    chk({31'h0, o_hotplug_irq_out}, 32'h0);
    rd_chk(8'hb0, tw(1'b0, 1'b0, 10'h4, 5'h3));
    // recommended prescale stored; too slow to run here
    wr(8'hb0, 4'hf, tw(1'b0, 1'b0, 10'h1, `HPT_PRESCALE_RECOMMENDED));
    rd_chk(8'hb0, tw(1'b0, 1'b0, 10'h1, `HPT_PRESCALE_RECOMMENDED));
    @(posedge i_clock);
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_rstn <= 1'b1;
    rd_chk(8'h2c, {SI_RST, SV_RST});
    rd_chk(8'hb0, 32'h0);
    wr(8'h2c, 4'h3, d2);
    rd_chk(8'h2c, {SI_RST, d2[15:0]});
    summarize();
  end
endmodule : test_hotplug_timer_cfg_regs
`default_nettype wire
